// >>> logic/hwp_params.svh
// Constants of the haptic waveform playback block: offsets, fields, resets, timing.
// Assumes a 100 MHz pclk and a 32-bit APB register bus.
// Overview of operation
// - Drive values are signed two's complement; magnitude is strength, sign is direction.
// - Closed loop: positive asks acceleration; zero or negative triggers automatic braking.
// - Open loop: both signs drive; with open-loop auto brake, negatives mean brake.
// - Open loop full scale equals overdrive clamp level; zero input gives no drive.
// - Open-loop negative drive reverses a rotating mass, phase-flips a linear actuator.
// - Closed loop output may overshoot rated level but never exceeds the clamp level.
// - Closed-loop overdrive longer than the time limit gets the post-limit clamp until braking.
// - Closed-loop braking may overdrive only for the time limit, then the post-limit clamp applies.
// - Playback starts on launch bit written one or on an external trigger.
// - Writing zero to the launch bit or a stop trigger ends playback early.
// - Real-time playback drives continuously from the current real-time amplitude value.
// - Real-time playback stops when the operating selection leaves real-time.
// - Sequencer plays slots from one upward, stopping at a zero slot or slot eight.
// - A slot holds a 7-bit waveform index; with top bit set, waits value x 10ms.
// - Each slot waveform repeats its slot repeat count before the next slot.
// - The whole sequence replays as many times as the sequence repeat count.
// - With the trigger pin in level function, the launch bit cannot trigger.
// - Real-time playback continues indefinitely until a stop condition.
// - Sequencer runs to its end then goes to standby, unless repeating forever.
// - With brake before standby set, a brake phase precedes standby.
`ifndef HWP_PARAMS_SVH
`define HWP_PARAMS_SVH

`define HWP_OFF_CTRL 8'h00
`define HWP_OFF_GO 8'h04
`define HWP_OFF_LEVELS 8'h08
`define HWP_OFF_ODTIME 8'h0C
`define HWP_OFF_SLOTS_LO 8'h10
`define HWP_OFF_SLOTS_HI 8'h14
`define HWP_OFF_REPEAT 8'h18
`define HWP_OFF_STATUS 8'h1C
`define HWP_OFF_LAST 8'h1C

`define HWP_CTRL_MODE 0
`define HWP_CTRL_CLOSED 1
`define HWP_CTRL_OL_BRAKE 2
`define HWP_CTRL_BBS 3
`define HWP_CTRL_RESONANT 4
`define HWP_CTRL_TPF_LSB 5
`define HWP_CTRL_W 7

`define HWP_CTRL_RST 7'h02
`define HWP_LEVELS_RST 32'h60FF507F
`define HWP_SLOTS_LO_RST 32'h00000001
`define HWP_SLOTS_HI_RST 32'h00000000
`define HWP_REPEAT_RST 19'h00000
`define HWP_ODTIME_RST 2'h0

`define HWP_MODE_REALTIME 1'b0
`define HWP_TPF_PULSE 2'h0
`define HWP_TPF_LEVEL 2'h1
`define HWP_SEQ_INFINITE 3'h7
`define HWP_LAST_SLOT 3'h7

`define HWP_CLK_MHZ 100
`define HWP_TICK_US 1000
`define HWP_TICK_CYCLES (`HWP_TICK_US * `HWP_CLK_MHZ)
`define HWP_WAIT_UNIT_MS 10
`define HWP_BRAKE_MS 20
`define HWP_OD_STEP_MS 5

`endif

// >>> logic/hwp_pkg.sv
// Types shared by the haptic waveform playback block.
// Assumes nothing beyond a SystemVerilog package scope.
package hwp_pkg;

  typedef enum logic [2:0] {st_idle, st_rt, st_load, st_wave, st_wait, st_brake} hwp_state_t;

endpackage

// >>> logic/hwp_drive_shaper.sv
// Drive shaper: turns a signed drive value into magnitude, direction and brake.
// Assumes a one-cycle millisecond tick and settings held stable by software.
`timescale 1ns/1ps
`include "hwp_params.svh"

module hwp_drive_shaper (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ms_tick,
  input wire logic en,
  input wire logic brake_force,
  input wire logic closed_loop,
  input wire logic ol_auto_brake,
  input wire logic resonant,
  input wire logic [7:0] value,
  input wire logic [7:0] rated,
  input wire logic [7:0] clamp,
  input wire logic [7:0] post_clamp,
  input wire logic [1:0] od_limit,
  output logic [7:0] level_r,
  output logic reverse_r,
  output logic phase_flip_r,
  output logic brake_r,
  output logic od_locked_r
);

  logic [7:0] mag;
  logic [7:0] raw;
  logic [7:0] limited;
  logic [7:0] od_ms;
  logic [7:0] od_cnt_r;
  logic brake_now;
  logic rev_now;
  logic flip_now;
  logic active;
  logic over;

  function automatic logic [7:0] hwp_scale(input logic [7:0] m, input logic [7:0] r);
    logic [15:0] p;
    p = {8'h00, m} * {8'h00, r};
    return p[14:7];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  assign active = en || brake_force;
  assign od_ms = 8'(({6'h00, od_limit} + 8'h01) * 8'(`HWP_OD_STEP_MS));

  always_comb
  begin
    mag = value[7] ? 8'(~value + 8'h01) : value;
    raw = 8'h00;
    brake_now = 1'b0;
    rev_now = 1'b0;
    flip_now = 1'b0;
    if (brake_force)
    begin
      brake_now = 1'b1;
      raw = clamp;
    end
    else if (!en)
    begin
      raw = 8'h00;
    end
    else if (closed_loop)
    begin
      if (value[7] || value == 8'h00)
      begin
        brake_now = 1'b1;
        raw = clamp;
      end
      else
      begin
        raw = hwp_scale(mag, clamp);
      end
    end
    else
    begin
      raw = hwp_scale(mag, clamp);
      if (value[7])
      begin
        if (ol_auto_brake)
          brake_now = 1'b1;
        else if (resonant)
          flip_now = 1'b1;
        else
          rev_now = 1'b1;
      end
    end
  end

  assign over = closed_loop && active && (raw > rated);
  assign limited = (od_locked_r && over && raw > post_clamp) ? post_clamp : raw;

  ////////////////////////////////////////////////////////////////////////////////
  // Overdrive timer restarts whenever drive turns into brake or back
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      od_cnt_r <= 8'h00;
      od_locked_r <= 1'b0;
    end
    else if (!active || brake_now != brake_r)
    begin
      od_cnt_r <= 8'h00;
      od_locked_r <= 1'b0;
    end
    else if (over && ms_tick && !od_locked_r)
    begin
      od_cnt_r <= 8'(od_cnt_r + 8'h01);
      if (8'(od_cnt_r + 8'h01) >= od_ms)
        od_locked_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_r <= 8'h00;
      brake_r <= 1'b0;
      reverse_r <= 1'b0;
      phase_flip_r <= 1'b0;
    end
    else
    begin
      level_r <= limited;
      brake_r <= brake_now;
      reverse_r <= rev_now;
      phase_flip_r <= flip_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_clamp_ceiling: assert property (1'b1 |=> level_r <= $past(clamp))
    else $error("drive level above overdrive clamp");
  a_midscale_off: assert property (en && !brake_force && value == 8'h00 && !closed_loop |=> level_r == 8'h00)
    else $error("zero open-loop input produced drive");
  a_closed_brake: assert property (en && closed_loop && (value[7] || value == 8'h00) |=> brake_r)
    else $error("closed loop non-positive value did not brake");
  a_ol_auto_brake: assert property (en && !brake_force && !closed_loop && value[7] && ol_auto_brake
    |=> brake_r && !reverse_r && !phase_flip_r)
    else $error("open loop auto brake not taken");
  a_lock_cap: assert property (od_locked_r && closed_loop && brake_now == brake_r && raw > rated
    |=> level_r <= $past(post_clamp))
    else $error("post-limit clamp not enforced");
  a_resonant_flip: assert property (en && !brake_force && !closed_loop && value[7] && !ol_auto_brake && resonant
    |=> phase_flip_r && !reverse_r)
    else $error("linear actuator negative drive not phase shifted");

endmodule

// >>> logic/hwp_playback.sv
// Playback controller: APB registers, trigger handling, real-time and sequencer playback.
// Assumes an APB master on pclk, a waveform library that answers lib_start with samples
// and lib_done, and a trigger pin synchronous to pclk.
`timescale 1ns/1ps
`include "hwp_params.svh"

module hwp_playback #(
  parameter int ADDR_W = 8,
  parameter int MS_TICK_CYCLES = `HWP_TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trig_in,
  input wire logic [7:0] lib_sample,
  input wire logic lib_done,
  output logic [6:0] lib_index,
  output logic lib_start,
  output logic [7:0] drive_level,
  output logic drive_reverse,
  output logic drive_phase_flip,
  output logic drive_brake,
  output logic playing
);

  // Refuse widths the address decode and tick divider cannot serve
  if (ADDR_W < 6 || MS_TICK_CYCLES < 2)
  begin : g_param_check
    $error("hwp_playback: ADDR_W must be at least 6 and MS_TICK_CYCLES at least 2");
  end

  hwp_pkg::hwp_state_t state_r;
  hwp_pkg::hwp_state_t state_nxt;
  logic [`HWP_CTRL_W-1:0] ctrl_r;
  logic [31:0] levels_r;
  logic [1:0] odtime_r;
  logic [31:0] slots_lo_r;
  logic [31:0] slots_hi_r;
  logic [18:0] repeat_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [6:0] lib_index_r;
  logic [6:0] lib_index_nxt;
  logic lib_start_r;
  logic lib_start_nxt;
  logic playing_r;
  logic [2:0] idx_r;
  logic [2:0] idx_nxt;
  logic [1:0] rep_r;
  logic [1:0] rep_nxt;
  logic [2:0] main_r;
  logic [2:0] main_nxt;
  logic [10:0] wait_r;
  logic [10:0] wait_nxt;
  logic [7:0] brk_r;
  logic [7:0] brk_nxt;
  logic [31:0] tick_cnt_r;
  logic ms_tick;
  logic trig_q_r;
  logic trig_rise;
  logic trig_fall;
  logic setup;
  logic acc_wr;
  logic [3:0] setup_hit;
  logic [3:0] acc_hit;
  logic go_wr;
  logic go_start;
  logic go_stop;
  logic start_req;
  logic stop_req;
  logic busy;
  logic [1:0] tpf;
  logic [7:0] cur_slot;
  logic [7:0] shp_value;
  logic shp_en;
  logic shp_brake;
  logic adv;
  logic pass_end;
  logic finish;
  logic [31:0] rd_mux;

  // Bit 3 flags a mapped word, bits 2:0 give its word index
  function automatic logic [3:0] hwp_hit(input logic [ADDR_W-1:0] a);
    logic ok;
    ok = (a[1:0] == 2'b00) && (a <= ADDR_W'(`HWP_OFF_LAST));
    return {ok, a[4:2]};
  endfunction

  function automatic logic [7:0] hwp_slot(input logic [31:0] lo, input logic [31:0] hi, input logic [2:0] i);
    logic [63:0] all;
    all = {hi, lo};
    return all[{i, 3'b000} +: 8];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait-free access, answer registered in the setup cycle
  assign setup = psel && !penable;
  assign setup_hit = hwp_hit(paddr);
  assign acc_hit = hwp_hit(paddr);
  assign acc_wr = psel && penable && pready_r && pwrite && acc_hit[3] && !pslverr_r;
  assign tpf = ctrl_r[`HWP_CTRL_TPF_LSB +: 2];
  assign go_wr = acc_wr && acc_hit[2:0] == `HWP_OFF_GO >> 2;
  assign go_start = go_wr && pwdata[0] && tpf != `HWP_TPF_LEVEL;
  assign go_stop = go_wr && !pwdata[0] && tpf != `HWP_TPF_LEVEL;

  always_comb
  begin
    rd_mux = 32'h00000000;
    case (setup_hit[2:0])
      3'h0: rd_mux = {25'h0000000, ctrl_r};
      3'h1: rd_mux = {31'h00000000, playing_r};
      3'h2: rd_mux = levels_r;
      3'h3: rd_mux = {30'h00000000, odtime_r};
      3'h4: rd_mux = slots_lo_r;
      3'h5: rd_mux = slots_hi_r;
      3'h6: rd_mux = {13'h0000, repeat_r};
      3'h7: rd_mux = {8'h00, drive_level, 5'h00, main_r, rep_r, idx_r, 3'(state_r)};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end
    else
    begin
      pready_r <= setup;
      pslverr_r <= setup && !setup_hit[3];
      if (setup && !pwrite && setup_hit[3])
        prdata_r <= rd_mux;
      else if (setup)
        prdata_r <= 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= `HWP_CTRL_RST;
      levels_r <= `HWP_LEVELS_RST;
      odtime_r <= `HWP_ODTIME_RST;
      slots_lo_r <= `HWP_SLOTS_LO_RST;
      slots_hi_r <= `HWP_SLOTS_HI_RST;
      repeat_r <= `HWP_REPEAT_RST;
    end
    else if (acc_wr)
    begin
      case (acc_hit[2:0])
        3'h0: ctrl_r <= pwdata[`HWP_CTRL_W-1:0];
        3'h2: levels_r <= pwdata;
        3'h3: odtime_r <= pwdata[1:0];
        3'h4: slots_lo_r <= pwdata;
        3'h5: slots_hi_r <= pwdata;
        3'h6: repeat_r <= pwdata[18:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Millisecond tick and trigger edges
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_cnt_r <= 32'h00000000;
    else if (tick_cnt_r == 32'(MS_TICK_CYCLES - 1))
      tick_cnt_r <= 32'h00000000;
    else
      tick_cnt_r <= tick_cnt_r + 32'h00000001;
  end
  assign ms_tick = tick_cnt_r == 32'(MS_TICK_CYCLES - 1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trig_q_r <= 1'b0;
    else
      trig_q_r <= trig_in;
  end

  assign trig_rise = trig_in && !trig_q_r;
  assign trig_fall = !trig_in && trig_q_r;
  assign busy = state_r inside {hwp_pkg::st_rt, hwp_pkg::st_load, hwp_pkg::st_wave, hwp_pkg::st_wait};
  // Pulse function toggles start and stop; level function follows the pin
  assign start_req = go_start || (tpf == `HWP_TPF_PULSE && trig_rise && !busy) ||
                     (tpf == `HWP_TPF_LEVEL && trig_rise);
  assign stop_req = go_stop || (tpf == `HWP_TPF_PULSE && trig_rise && busy) ||
                    (tpf == `HWP_TPF_LEVEL && trig_fall);

  ////////////////////////////////////////////////////////////////////////////////
  // Playback sequencing
  assign cur_slot = hwp_slot(slots_lo_r, slots_hi_r, idx_r);

  always_comb
  begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    rep_nxt = rep_r;
    main_nxt = main_r;
    wait_nxt = wait_r;
    brk_nxt = brk_r;
    lib_index_nxt = lib_index_r;
    lib_start_nxt = 1'b0;
    adv = 1'b0;
    pass_end = 1'b0;
    finish = 1'b0;
    case (state_r)
      hwp_pkg::st_idle:
        if (start_req)
        begin
          idx_nxt = 3'h0;
          rep_nxt = 2'h0;
          main_nxt = 3'h0;
          state_nxt = (ctrl_r[`HWP_CTRL_MODE] == `HWP_MODE_REALTIME) ? hwp_pkg::st_rt : hwp_pkg::st_load;
        end
      hwp_pkg::st_rt:
        if (ctrl_r[`HWP_CTRL_MODE] != `HWP_MODE_REALTIME)
          finish = 1'b1;
      hwp_pkg::st_load:
        if (cur_slot == 8'h00)
          pass_end = 1'b1;
        else if (cur_slot[7])
        begin
          wait_nxt = 11'({4'h0, cur_slot[6:0]} * 11'(`HWP_WAIT_UNIT_MS));
          state_nxt = hwp_pkg::st_wait;
        end
        else
        begin
          lib_index_nxt = cur_slot[6:0];
          lib_start_nxt = 1'b1;
          state_nxt = hwp_pkg::st_wave;
        end
      hwp_pkg::st_wave:
        if (lib_done)
        begin
          if (rep_r < repeat_r[{idx_r, 1'b0} +: 2])
          begin
            rep_nxt = 2'(rep_r + 2'h1);
            state_nxt = hwp_pkg::st_load;
          end
          else
            adv = 1'b1;
        end
      hwp_pkg::st_wait:
        if (wait_r == 11'h000)
          adv = 1'b1;
        else if (ms_tick)
          wait_nxt = 11'(wait_r - 11'h001);
      hwp_pkg::st_brake:
        if (brk_r == 8'h00)
          state_nxt = hwp_pkg::st_idle;
        else if (ms_tick)
          brk_nxt = 8'(brk_r - 8'h01);
      default:
        state_nxt = hwp_pkg::st_idle;
    endcase
    if (adv)
    begin
      rep_nxt = 2'h0;
      if (idx_r == `HWP_LAST_SLOT)
        pass_end = 1'b1;
      else
      begin
        idx_nxt = 3'(idx_r + 3'h1);
        state_nxt = hwp_pkg::st_load;
      end
    end
    if (pass_end)
    begin
      if (repeat_r[18:16] == `HWP_SEQ_INFINITE || main_r < repeat_r[18:16])
      begin
        if (repeat_r[18:16] != `HWP_SEQ_INFINITE)
          main_nxt = 3'(main_r + 3'h1);
        idx_nxt = 3'h0;
        rep_nxt = 2'h0;
        state_nxt = hwp_pkg::st_load;
      end
      else
        finish = 1'b1;
    end
    if (busy && stop_req)
      finish = 1'b1;
    if (finish)
    begin
      lib_start_nxt = 1'b0;
      brk_nxt = 8'(`HWP_BRAKE_MS);
      state_nxt = ctrl_r[`HWP_CTRL_BBS] ? hwp_pkg::st_brake : hwp_pkg::st_idle;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= hwp_pkg::st_idle;
      idx_r <= 3'h0;
      rep_r <= 2'h0;
      main_r <= 3'h0;
      wait_r <= 11'h000;
      brk_r <= 8'h00;
      lib_index_r <= 7'h00;
      lib_start_r <= 1'b0;
      playing_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      rep_r <= rep_nxt;
      main_r <= main_nxt;
      wait_r <= wait_nxt;
      brk_r <= brk_nxt;
      lib_index_r <= lib_index_nxt;
      lib_start_r <= lib_start_nxt;
      playing_r <= state_nxt != hwp_pkg::st_idle;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Drive path: real-time amplitude or library sample, nothing in wait steps
  assign shp_en = state_r == hwp_pkg::st_rt || state_r == hwp_pkg::st_wave;
  assign shp_value = (state_r == hwp_pkg::st_rt) ? levels_r[7:0] : lib_sample;
  assign shp_brake = state_r == hwp_pkg::st_brake;

  hwp_drive_shaper u_shaper (
    .pclk(pclk),
    .presetn(presetn),
    .ms_tick(ms_tick),
    .en(shp_en),
    .brake_force(shp_brake),
    .closed_loop(ctrl_r[`HWP_CTRL_CLOSED]),
    .ol_auto_brake(ctrl_r[`HWP_CTRL_OL_BRAKE]),
    .resonant(ctrl_r[`HWP_CTRL_RESONANT]),
    .value(shp_value),
    .rated(levels_r[15:8]),
    .clamp(levels_r[23:16]),
    .post_clamp(levels_r[31:24]),
    .od_limit(odtime_r),
    .level_r(drive_level),
    .reverse_r(drive_reverse),
    .phase_flip_r(drive_phase_flip),
    .brake_r(drive_brake),
    .od_locked_r()
  );

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign lib_index = lib_index_r;
  assign lib_start = lib_start_r;
  assign playing = playing_r;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_stop_bbs;
    finish && ctrl_r[`HWP_CTRL_BBS];
  endsequence

  sequence s_brake_then_idle;
    state_r == hwp_pkg::st_brake ##1 (state_r == hwp_pkg::st_brake || state_r == hwp_pkg::st_idle);
  endsequence

  a_go_launch: assert property (state_r == hwp_pkg::st_idle && go_start |=> state_r != hwp_pkg::st_idle)
    else $error("launch bit did not start playback");
  a_level_no_go: assert property (state_r == hwp_pkg::st_idle && go_wr && pwdata[0] && tpf == `HWP_TPF_LEVEL
    && !trig_rise |=> state_r == hwp_pkg::st_idle)
    else $error("launch bit started playback in level trigger function");
  a_go_stop: assert property (busy && go_stop |=> state_r == hwp_pkg::st_idle || state_r == hwp_pkg::st_brake)
    else $error("writing zero to launch bit did not stop");
  a_rt_leave: assert property (state_r == hwp_pkg::st_rt && ctrl_r[`HWP_CTRL_MODE] != `HWP_MODE_REALTIME
    |=> state_r != hwp_pkg::st_rt)
    else $error("real-time playback kept running after mode change");
  a_wait_silent: assert property (state_r == hwp_pkg::st_wait |=> drive_level == 8'h00 && !drive_brake)
    else $error("drive present during wait step");
  a_brake_entry: assert property (s_stop_bbs |=> s_brake_then_idle)
    else $error("brake phase missing before standby");
  a_seq_end: assert property (state_r == hwp_pkg::st_load && cur_slot == 8'h00 && !stop_req
    && repeat_r[18:16] != `HWP_SEQ_INFINITE && main_r >= repeat_r[18:16] && !ctrl_r[`HWP_CTRL_BBS]
    |=> state_r == hwp_pkg::st_idle && !playing)
    else $error("sequence did not end at zero slot");
  a_apb_ready: assert property (setup |=> pready_r ##1 !pready_r)
    else $error("apb ready not a single access cycle");
  a_wave_request: assert property (state_r == hwp_pkg::st_load && cur_slot != 8'h00 && !cur_slot[7] && !stop_req
    |=> lib_start && lib_index == $past(cur_slot[6:0]))
    else $error("slot waveform not requested");

endmodule

// >>> dv/hwp_lib_model.sv
// Waveform library model: answers each lib_start with samples, then a one-cycle lib_done.
// Assumes lib_start is a one-cycle pulse on pclk; outside a waveform the sample toggles.
`timescale 1ns/1ps

module hwp_lib_model #(
  parameter int DUR = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic lib_start,
  input wire logic [6:0] lib_index,
  output logic [7:0] lib_sample,
  output logic lib_done,
  output logic [7:0] starts,
  output logic [6:0] last_index
);
  int cnt;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 0;
      lib_done <= 1'b0;
      lib_sample <= 8'h5A;
      starts <= 8'h00;
      last_index <= 7'h00;
    end
    else
    begin
      lib_done <= (cnt == 1);
      lib_sample <= (cnt > 0) ? 8'h40 : ~lib_sample;
      if (lib_start)
      begin
        cnt <= DUR;
        starts <= starts + 8'h01;
        last_index <= lib_index;
      end
      else if (cnt > 0)
        cnt <= cnt - 1;
    end
  end
endmodule

// >>> dv/tb_top.sv
// Bench for the playback controller: APB register tasks, trigger pin and library model.
// Assumes the zero-wait APB slave and 4-cycle millisecond tick set below.
`timescale 1ns/1ps
`include "hwp_params.svh"

module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, trig_in, lib_done, lib_start;
  logic drive_reverse, drive_phase_flip, drive_brake, playing, err, saw_brake;
  logic [7:0] paddr, lib_sample, drive_level, starts;
  logic [6:0] lib_index, last_index;
  logic [31:0] pwdata, prdata, rd;
  int bad_count, checks_done;
  logic [6:0] ctab [6] = '{7'h00, 7'h00, 7'h10, 7'h04, 7'h02, 7'h02};
  logic [7:0] vtab [6] = '{8'h80, 8'h40, 8'h80, 8'h80, 8'h00, 8'h7F};
  logic [2:0] ftab [6] = '{3'b001, 3'b000, 3'b010, 3'b100, 3'b100, 3'b000};

  hwp_playback #(.ADDR_W(8), .MS_TICK_CYCLES(4)) hwp_playback_i (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_in(trig_in), .lib_sample(lib_sample), .lib_done(lib_done),
    .lib_index(lib_index), .lib_start(lib_start), .drive_level(drive_level), .drive_reverse(drive_reverse),
    .drive_phase_flip(drive_phase_flip), .drive_brake(drive_brake), .playing(playing));
  hwp_lib_model #(.DUR(3)) hwp_lib_model_i (.pclk(pclk), .presetn(presetn), .lib_start(lib_start),
    .lib_index(lib_index), .lib_sample(lib_sample), .lib_done(lib_done), .starts(starts),
    .last_index(last_index));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer, entered just after a rising edge; waits for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    saw_brake = 1'b0;
    while (playing !== 1'b0 && n < 3000)
    begin
      @(posedge pclk);
      n++;
      saw_brake = saw_brake | (drive_brake === 1'b1);
    end
  endtask

  task automatic seq(input logic [31:0] lo, hi, rep, input logic [6:0] c, input int n, input logic [6:0] last);
    logic [7:0] s0;
    apb(1, `HWP_OFF_CTRL, {25'h0, c});
    apb(1, `HWP_OFF_SLOTS_LO, lo);
    apb(1, `HWP_OFF_SLOTS_HI, hi);
    apb(1, `HWP_OFF_REPEAT, rep);
    s0 = starts;
    apb(1, `HWP_OFF_GO, 32'h1);
    chk(playing, 1);
    wait_idle;
    chk(playing, 0);
    chk(8'(starts - s0), n);
    chk(last_index, last);
    $display("sequence test done");
  endtask

  initial
  begin
    #500000;
    bad_count++;
    end_of_test;
  end

  initial
  begin
    presetn <= 1'b0;
    {psel, penable, pwrite, trig_in, paddr, pwdata} <= '0;
    cyc(5);
    presetn <= 1'b1;
    cyc(1);
    apb(0, `HWP_OFF_CTRL, 0);
    chk(rd, {25'h0, `HWP_CTRL_RST});
    apb(0, `HWP_OFF_LEVELS, 0);
    chk(rd, `HWP_LEVELS_RST);
    apb(0, `HWP_OFF_SLOTS_LO, 0);
    chk(rd, `HWP_SLOTS_LO_RST);
    apb(0, 8'h20, 0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    apb(1, 8'h02, 32'h1);
    chk(err, 1);
    $display("register test done");
    apb(1, `HWP_OFF_CTRL, 0);
    apb(1, `HWP_OFF_LEVELS, 32'h60FF5080);
    apb(1, `HWP_OFF_GO, 32'h1);
    cyc(3);
    chk({playing, drive_level}, 9'h1FF);
    for (int i = 0; i < 6; i++)
    begin
      apb(1, `HWP_OFF_CTRL, {25'h0, ctab[i]});
      apb(1, `HWP_OFF_LEVELS, {24'h60FF50, vtab[i]});
      cyc(3);
      chk({drive_brake, drive_phase_flip, drive_reverse}, ftab[i]);
    end
    chk(drive_level, 8'hFD);
    cyc(30);
    chk(drive_level, 8'h60);
    apb(1, `HWP_OFF_LEVELS, 32'h60FF5080);
    cyc(3);
    chk({drive_brake, drive_level}, 9'h1FF);
    cyc(30);
    chk({drive_brake, drive_level}, 9'h160);
    apb(1, `HWP_OFF_CTRL, 32'h3);
    cyc(3);
    chk(playing, 0);
    $display("real-time test done");
    seq(32'h00008205, 0, 32'h00010001, 7'h01, 4, 7'h05);
    seq(32'h04030201, 32'h08070605, 0, 7'h01, 8, 7'h08);
    apb(1, `HWP_OFF_REPEAT, 32'h00070000);
    apb(1, `HWP_OFF_GO, 32'h1);
    cyc(40);
    chk(playing, 1);
    apb(1, `HWP_OFF_GO, 32'h0);
    cyc(3);
    chk(playing, 0);
    trig_in <= 1'b1;
    cyc(3);
    chk(playing, 1);
    trig_in <= 1'b0;
    cyc(2);
    trig_in <= 1'b1;
    cyc(3);
    chk(playing, 0);
    trig_in <= 1'b0;
    apb(1, `HWP_OFF_CTRL, 32'h21);
    apb(1, `HWP_OFF_GO, 32'h1);
    cyc(3);
    chk(playing, 0);
    trig_in <= 1'b1;
    cyc(3);
    chk(playing, 1);
    trig_in <= 1'b0;
    cyc(3);
    chk(playing, 0);
    $display("trigger test done");
    seq(32'h00000009, 0, 0, 7'h09, 1, 7'h09);
    chk(saw_brake, 1);
    end_of_test;
  end
endmodule
